// ===== uapm_params.svh
`ifndef UAPM_PARAMS_SVH
`define UAPM_PARAMS_SVH

// ****************************************************************
// register map, byte addresses on the avalon bus
// ****************************************************************
`define UAPM_ADDR_W            16
`define UAPM_PINSEL_OFS        16'h1c30
`define UAPM_BOOT_OFS          16'h1c34

// ****************************************************************
// field layout and reset values
// ****************************************************************
`define UAPM_NPINS             6
`define UAPM_SEL_LSB           0
`define UAPM_SEL_MSB           5
`define UAPM_RSVD_LSB          6
`define UAPM_RSVD_MSB          7
`define UAPM_BOOT_LSB          0
`define UAPM_BOOT_MSB          5
`define UAPM_BOOT_VALID_BIT    8
`define UAPM_PINSEL_RST        6'h3f
`define UAPM_BOOT_RST          6'h00

// ****************************************************************
// timing counts, in core_clk cycles
// ****************************************************************
`define UAPM_BOOT_CAPTURE_CYCLES 10
`define UAPM_CAP_CNT_W         4

`endif

// ===== uapm_pkg.sv
package uapm_pkg;

    // ****************************************************************
    // types shared by the mux and its pin cells
    // ****************************************************************
    // drive of one shared pin: level and output enable
    typedef struct packed {
        logic out;
        logic oe;
    } uapm_drive_t;

    // avalon request as seen by the slave
    typedef struct packed {
        logic [15:0] address;
        logic        read;
        logic        write;
        logic [31:0] writedata;
        logic [3:0]  byteenable;
    } uapm_avs_req_t;

    // bus answer sequencer
    typedef enum logic [1:0] {
        UAPM_BUS_IDLE   = 2'b01,
        UAPM_BUS_ANSWER = 2'b10
    } uapm_bus_st_t;

    // boot level capture sequencer
    typedef enum logic [1:0] {
        UAPM_CAP_COUNT = 2'b01,
        UAPM_CAP_DONE  = 2'b10
    } uapm_cap_st_t;

endpackage

// ===== uapm_pin_cell.sv
`timescale 1ns/1ps

// ****************************************************************
// one shared pin: memory address or general i/o
// ****************************************************************
module uapm_pin_cell (
    input  wire logic                core_clk,
    input  wire logic                rst_n,
    input  wire logic                gpio_sel,
    input  wire logic                ext_mem_address_line,
    input  wire logic                gpio_out,
    input  wire logic                gpio_oe,
    input  wire logic                pin_in,
    output uapm_pkg::uapm_drive_t    drive,
    output logic                     gpio_in
);

    // registered drive; reset leaves the pin an undriven input
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            drive.out <= 1'b0;
            drive.oe  <= 1'b0;
        end else if (!gpio_sel) begin
            drive.out <= ext_mem_address_line;  // memory owns the pin
            drive.oe  <= 1'b1;
        end else begin
            drive.out <= gpio_out;              // i/o block owns the pin
            drive.oe  <= gpio_oe;
        end
    end

    // pin level back to the i/o block
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            gpio_in <= 1'b0;
        end else begin
            gpio_in <= pin_in;
        end
    end

endmodule

// ===== uapm_top.sv
// Design decisions made here: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "uapm_params.svh"

// Notes on behaviour
// - bit 5 selects address 20 or io 26
// - bit 4 selects address 19 or io 25
// - bit 3 selects address 18 or io 24
// - bit 2 selects address 17 or io 23
// - bit 1 selects address 16 or io 22
// - bit 0 selects address 15 or io 21
// - reset: io function, pin undriven input
// - pins captured ten cycles after reset release
// - captured levels form boot method field
// - reserved bits 7:6 read-only, writes ignored

module uapm_top #(
    parameter int NPINS               = `UAPM_NPINS,
    parameter int BOOT_CAPTURE_CYCLES = `UAPM_BOOT_CAPTURE_CYCLES
) (
    input  wire logic                            core_clk,
    input  wire logic                            rst_n,
    input  wire logic [`UAPM_ADDR_W-1:0]         address,
    input  wire logic                            read,
    input  wire logic                            write,
    input  wire logic [31:0]                     writedata,
    input  wire logic [3:0]                      byteenable,
    output logic      [31:0]                     readdata,
    output logic                                 waitrequest,
    input  wire logic [NPINS-1:0]                ext_mem_address_line,
    input  wire logic [NPINS-1:0]                general_io_line_out,
    input  wire logic [NPINS-1:0]                general_io_line_oe,
    output logic      [NPINS-1:0]                general_io_line_in,
    input  wire logic [NPINS-1:0]                pin_in,
    output uapm_pkg::uapm_drive_t [NPINS-1:0]    pin_drive,
    output logic      [NPINS-1:0]                addr_line_select,
    output logic      [NPINS-1:0]                boot_method_field
);

    // ****************************************************************
    // state
    // ****************************************************************
    uapm_pkg::uapm_avs_req_t              req;
    uapm_pkg::uapm_bus_st_t               bus_st_q;
    uapm_pkg::uapm_cap_st_t               cap_st_q;
    logic [NPINS-1:0]                     sel_q;
    logic [NPINS-1:0]                     boot_q;
    logic                                 boot_valid_q;
    logic [`UAPM_CAP_CNT_W-1:0]           cap_cnt_q;
    logic                                 cap_fire;
    logic                                 hit_pinsel;
    logic                                 hit_boot;
    logic [31:0]                          rd_d;

    // bundle the bus inputs
    assign req.address    = address;
    assign req.read       = read;
    assign req.write      = write;
    assign req.writedata  = writedata;
    assign req.byteenable = byteenable;

    // ****************************************************************
    // avalon slave: one wait cycle, then answer
    // ****************************************************************
    // address decode
    always_comb begin
        hit_pinsel = 1'b0;
        hit_boot   = 1'b0;
        if (req.address == `UAPM_PINSEL_OFS) begin
            hit_pinsel = 1'b1;
        end else if (req.address == `UAPM_BOOT_OFS) begin
            hit_boot = 1'b1;
        end
    end

    // read mux; unmapped and reserved bits read zero
    always_comb begin
        rd_d = 32'h0000_0000;
        if (hit_pinsel) begin
            rd_d[`UAPM_SEL_MSB:`UAPM_SEL_LSB] = sel_q;   // 7:6 stay 0
        end else if (hit_boot) begin
            rd_d[`UAPM_BOOT_MSB:`UAPM_BOOT_LSB] = boot_q;
            rd_d[`UAPM_BOOT_VALID_BIT]          = boot_valid_q;
        end
    end

    // answer sequencer; waitrequest high except in the answer cycle
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            bus_st_q    <= uapm_pkg::UAPM_BUS_IDLE;
            waitrequest <= 1'b1;
            readdata    <= 32'h0000_0000;
        end else begin
            case (bus_st_q)
                uapm_pkg::UAPM_BUS_IDLE: begin
                    if (req.read || req.write) begin
                        bus_st_q    <= uapm_pkg::UAPM_BUS_ANSWER;
                        waitrequest <= 1'b0;
                        readdata    <= req.read ? rd_d : 32'h0000_0000;
                    end
                end
                uapm_pkg::UAPM_BUS_ANSWER: begin
                    bus_st_q    <= uapm_pkg::UAPM_BUS_IDLE;
                    waitrequest <= 1'b1;
                end
                default: begin
                    bus_st_q    <= uapm_pkg::UAPM_BUS_IDLE;
                    waitrequest <= 1'b1;
                end
            endcase
        end
    end

    // ****************************************************************
    // pin select register
    // ****************************************************************
    // write lands at the edge where waitrequest is seen low
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            sel_q <= `UAPM_PINSEL_RST;                  // all io
        end else if (bus_st_q == uapm_pkg::UAPM_BUS_ANSWER && req.write
                     && hit_pinsel && req.byteenable[0]) begin
            sel_q <= req.writedata[`UAPM_SEL_MSB:`UAPM_SEL_LSB];
        end
    end

    // select levels also go out for the pad ring
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            addr_line_select <= `UAPM_PINSEL_RST;
        end else begin
            addr_line_select <= sel_q;
        end
    end

    // ****************************************************************
    // boot level capture after reset release
    // ****************************************************************
    assign cap_fire = (cap_st_q == uapm_pkg::UAPM_CAP_COUNT) &&
        (cap_cnt_q == `UAPM_CAP_CNT_W'(BOOT_CAPTURE_CYCLES - 1));

    // count cycles from release, capture once
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            cap_st_q  <= uapm_pkg::UAPM_CAP_COUNT;
            cap_cnt_q <= '0;
        end else begin
            case (cap_st_q)
                uapm_pkg::UAPM_CAP_COUNT: begin
                    if (cap_fire) begin
                        cap_st_q <= uapm_pkg::UAPM_CAP_DONE;
                    end else begin
                        cap_cnt_q <= cap_cnt_q + `UAPM_CAP_CNT_W'(1);
                    end
                end
                uapm_pkg::UAPM_CAP_DONE: begin
                    cap_st_q <= uapm_pkg::UAPM_CAP_DONE;
                end
                default: begin
                    cap_st_q <= uapm_pkg::UAPM_CAP_COUNT;
                end
            endcase
        end
    end

    // boot method field, bits 5:0 from pins 20:15
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            boot_q       <= `UAPM_BOOT_RST;
            boot_valid_q <= 1'b0;
        end else if (cap_fire) begin
            boot_q       <= pin_in;
            boot_valid_q <= 1'b1;
        end
    end

    // registered copy for the boot loader
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            boot_method_field <= `UAPM_BOOT_RST;
        end else begin
            boot_method_field <= boot_q;
        end
    end

    // ****************************************************************
    // per pin routing
    // ****************************************************************
    // bit n: 0 = address line 15+n, 1 = io line 21+n
    for (genvar i = 0; i < NPINS; i++) begin : g_pin
        uapm_pin_cell u_cell (
            .core_clk             (core_clk),
            .rst_n                (rst_n),
            .gpio_sel             (sel_q[i]),
            .ext_mem_address_line (ext_mem_address_line[i]),
            .gpio_out             (general_io_line_out[i]),
            .gpio_oe              (general_io_line_oe[i]),
            .pin_in               (pin_in[i]),
            .drive                (pin_drive[i]),
            .gpio_in              (general_io_line_in[i])
        );
    end

    // ****************************************************************
    // assertions
    // ****************************************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    a_pin20_route: assert property (
        !sel_q[5] |=> pin_drive[5].oe &&
            pin_drive[5].out == $past(ext_mem_address_line[5]))
        else $error("pin 5 not on address line 20");

    a_pin19_route: assert property (
        sel_q[4] |=> pin_drive[4].oe == $past(general_io_line_oe[4]) &&
            pin_drive[4].out == $past(general_io_line_out[4]))
        else $error("pin 4 not on io line 25");

    a_pin18_route: assert property (
        !sel_q[3] ##1 !sel_q[3] |-> pin_drive[3].oe &&
            pin_drive[3].out == $past(ext_mem_address_line[3]))
        else $error("pin 3 not on address line 18");

    a_pin17_route: assert property (
        sel_q[2] |=> pin_drive[2].out == $past(general_io_line_out[2]))
        else $error("pin 2 not on io line 23");

    a_pin16_route: assert property (
        !sel_q[1] |=> pin_drive[1].oe &&
            pin_drive[1].out == $past(ext_mem_address_line[1]))
        else $error("pin 1 not on address line 16");

    a_pin15_route: assert property (
        sel_q[0] |=> pin_drive[0].oe == $past(general_io_line_oe[0]))
        else $error("pin 0 not on io line 21");

    a_reset_io_input: assert property (
        $rose(rst_n) |-> sel_q == `UAPM_PINSEL_RST && pin_drive[0].oe == 1'b0
            && pin_drive[5].oe == 1'b0)
        else $error("pins not undriven io after reset");

    // valid only rises once per reset, so low at E9 means low since E0
    a_capture_time: assert property (
        $rose(rst_n) |-> !boot_valid_q ##9 !boot_valid_q ##1 boot_valid_q)
        else $error("boot levels not captured on time");

    a_boot_value: assert property (
        cap_fire |=> boot_q == $past(pin_in) ##1
            boot_method_field == $past(boot_q))
        else $error("boot field differs from captured pins");

    a_boot_hold: assert property (
        boot_valid_q |=> $stable(boot_q))
        else $error("boot field changed after capture");

    a_rsvd_zero: assert property (
        !waitrequest |-> readdata[`UAPM_RSVD_MSB:`UAPM_RSVD_LSB] == 2'b00)
        else $error("reserved bits read nonzero");

    a_sel_write: assert property (
        !waitrequest && write && hit_pinsel && byteenable[0] |=>
            sel_q == $past(writedata[`UAPM_SEL_MSB:`UAPM_SEL_LSB]))
        else $error("pin select write lost");

    a_bus_answer: assert property (
        waitrequest && (read || write) && bus_st_q == uapm_pkg::UAPM_BUS_IDLE
            |=> !waitrequest ##1 waitrequest)
        else $error("bus answer not one cycle after request");

    // main scenarios
    c_capture:   cover property (cap_fire);
    c_sel_write: cover property (!waitrequest && write && hit_pinsel);
    c_boot_read: cover property (!waitrequest && read && hit_boot);
    c_emif_mode: cover property (sel_q == 6'h00 ##1 pin_drive[5].oe);

endmodule

// ===== uapm_pin_model.sv
`timescale 1ns/1ps

// ****************************************************************
// far side of the shared pins: memory, io devices, board
// ****************************************************************
module uapm_pin_model (
    input  wire logic                        core_clk,
    input  wire uapm_pkg::uapm_drive_t [5:0] pin_drive,
    input  wire logic [5:0]                  ext_oe,
    input  wire logic [5:0]                  ext_level,
    output logic      [5:0]                  pin_in
);
    logic [5:0] float_q = 6'h2a;

    // undriven pins wander every cycle, no pull on the board
    always_ff @(posedge core_clk) begin
        float_q <= ~float_q;
    end

    // resolve each pin; both drivers at once is contention
    always_comb begin
        for (int i = 0; i < 6; i++) begin
            case ({pin_drive[i].oe, ext_oe[i]})
                2'b10:   pin_in[i] = pin_drive[i].out;
                2'b01:   pin_in[i] = ext_level[i];
                2'b11:   pin_in[i] = 1'bx;
                default: pin_in[i] = float_q[i];
            endcase
        end
    end
endmodule

// ===== uapm_top_tb.sv
`timescale 1ns/1ps
`include "uapm_params.svh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin errors++; \
    $display("Error t=%0t got=%h exp=%h", $time, (g), (e)); end end

module uapm_top_tb;
    logic                        core_clk;
    logic                        rst_n;
    logic [15:0]                 address;
    logic                        read;
    logic                        write;
    logic [31:0]                 writedata;
    logic [3:0]                  byteenable;
    logic [31:0]                 readdata;
    logic                        waitrequest;
    logic [5:0]                  mem_addr;
    logic [5:0]                  io_out;
    logic [5:0]                  io_oe;
    logic [5:0]                  io_in;
    logic [5:0]                  pin_in;
    uapm_pkg::uapm_drive_t [5:0] pin_drive;
    logic [5:0]                  addr_sel;
    logic [5:0]                  boot_field;
    logic [5:0]                  ext_oe;
    logic [5:0]                  ext_level;
    logic [31:0]                 rd;
    int                          errors;
    int                          n_tests;

    uapm_top u_uapm_top (
        .core_clk             (core_clk),
        .rst_n                (rst_n),
        .address              (address),
        .read                 (read),
        .write                (write),
        .writedata            (writedata),
        .byteenable           (byteenable),
        .readdata             (readdata),
        .waitrequest          (waitrequest),
        .ext_mem_address_line (mem_addr),
        .general_io_line_out  (io_out),
        .general_io_line_oe   (io_oe),
        .general_io_line_in   (io_in),
        .pin_in               (pin_in),
        .pin_drive            (pin_drive),
        .addr_line_select     (addr_sel),
        .boot_method_field    (boot_field)
    );

    uapm_pin_model u_uapm_pin_model (
        .core_clk  (core_clk),
        .pin_drive (pin_drive),
        .ext_oe    (ext_oe),
        .ext_level (ext_level),
        .pin_in    (pin_in)
    );

    // ****************************************************************
    // clock, bus master, closing
    // ****************************************************************
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    // one avalon transfer, held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [15:0] a,
                       input logic [31:0] wd, input logic [3:0] be);
        int n;
        n = 0;
        address    <= a;
        writedata  <= wd;
        byteenable <= be;
        read       <= ~wr;
        write      <= wr;
        do begin
            @(posedge core_clk);
            n++;
        end while (waitrequest !== 1'b0 && n < 64);
        rd = readdata;
        if (n >= 64) errors++;
        read  <= 1'b0;
        write <= 1'b0;
        @(posedge core_clk);
    endtask

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // ****************************************************************
    // scenarios
    // ****************************************************************
    // reset state, then boot levels taken on exactly one edge
    task automatic t_reset_boot();
        ext_oe    <= 6'h3f;
        ext_level <= 6'h15;
        repeat (20) @(posedge core_clk);
        for (int i = 0; i < 6; i++) `CHK(pin_drive[i].oe, 1'b0)
        `CHK(addr_sel, 6'h3f)
        rst_n <= 1'b1;
        repeat (9) @(posedge core_clk);
        ext_level <= 6'h2d;
        @(posedge core_clk);
        ext_level <= 6'h12;
        repeat (4) @(posedge core_clk);
        `CHK(boot_field, 6'h2d)
        bus(1'b0, `UAPM_BOOT_OFS, 32'h0, 4'hf);
        `CHK(rd, 32'h0000_012d)
        bus(1'b0, `UAPM_PINSEL_OFS, 32'h0, 4'hf);
        `CHK(rd, 32'h0000_003f)
        ext_oe <= 6'h00;
    endtask

    // each select bit alone to memory, the rest to io
    task automatic t_route();
        logic [5:0] sel;
        logic [1:0] exp;
        io_out <= 6'h15;
        io_oe  <= 6'h33;
        for (int i = 0; i < 6; i++) begin
            sel = ~(6'h01 << i);
            mem_addr <= 6'h2a ^ {6{i[0]}};
            bus(1'b1, `UAPM_PINSEL_OFS, {26'h0, sel}, 4'h1);
            repeat (2) @(posedge core_clk);
            `CHK(addr_sel, sel)
            for (int j = 0; j < 6; j++) begin
                exp = (j == i) ? {mem_addr[j], 1'b1} : {io_out[j], io_oe[j]};
                `CHK(pin_drive[j], exp)
            end
            `CHK(io_in[i], mem_addr[i])
        end
    endtask

    // reserved bits, lane enables, read-only and unmapped places
    task automatic t_regs();
        bus(1'b1, `UAPM_PINSEL_OFS, 32'hffff_ffc0, 4'hf);
        bus(1'b0, `UAPM_PINSEL_OFS, 32'h0, 4'hf);
        `CHK(rd, 32'h0000_0000)
        for (int i = 0; i < 6; i++) `CHK(pin_drive[i].oe, 1'b1)
        bus(1'b1, `UAPM_PINSEL_OFS, 32'h0000_00ff, 4'he);
        bus(1'b0, `UAPM_PINSEL_OFS, 32'h0, 4'hf);
        `CHK(rd, 32'h0000_0000)
        bus(1'b1, `UAPM_PINSEL_OFS, 32'h0000_00ff, 4'h1);
        bus(1'b0, `UAPM_PINSEL_OFS, 32'h0, 4'hf);
        `CHK(rd, 32'h0000_003f)
        bus(1'b1, `UAPM_BOOT_OFS, 32'h0, 4'hf);
        bus(1'b0, `UAPM_BOOT_OFS, 32'h0, 4'hf);
        `CHK(rd, 32'h0000_012d)
        bus(1'b1, 16'h1c38, 32'hffff_ffff, 4'hf);
        bus(1'b0, 16'h1c38, 32'h0, 4'hf);
        `CHK(rd, 32'h0000_0000)
    endtask

    // main sequence
    initial begin
        errors     = 0;
        n_tests    = 0;
        rst_n      <= 1'b0;
        address    <= 16'h0000;
        read       <= 1'b0;
        write      <= 1'b0;
        writedata  <= 32'h0;
        byteenable <= 4'h0;
        mem_addr   <= 6'h00;
        io_out     <= 6'h00;
        io_oe      <= 6'h00;
        ext_oe     <= 6'h3f;
        ext_level  <= 6'h15;
        t_reset_boot();
        t_route();
        t_regs();
        test_done();
    end

    // watchdog against a hung handshake
    initial begin
        repeat (5000) @(posedge core_clk);
        errors++;
        test_done();
    end
endmodule
